// [logic/aor_regs.sv]
`timescale 1ns/1ps
module aor_regs
  import aor_pkg::*;
#(
  parameter logic [AOR_TIMER_W-1:0] UNLOCK_CYCLES = AOR_TIMER_W'(AOR_UNLOCK_CYCLES)
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [AOR_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [AOR_DW-1:0] reg_wdata_i,
  output logic [AOR_DW-1:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  input wire logic login_ok_i,
  input wire logic [AOR_CH_COUNT*32-1:0] mean_one_i,
  input wire logic [AOR_CH_COUNT*32-1:0] mean_two_i,
  output logic [AOR_CH_COUNT-1:0] alarm_ack_o,
  output logic [AOR_CH_COUNT*AOR_FORCE_W-1:0] forced_state_o,
  output logic password_active_o,
  output logic write_unlocked_o,
  output logic [7:0] gateway_main_version_o,
  output logic [15:0] gateway_patch_sub_version_o,
  output logic [7:0] gateway_hardware_revision_o,
  output logic [47:0] unique_node_identifier_o
);
  logic [AOR_DW-1:0] ack_sig_q [AOR_CH_COUNT];
  logic [AOR_DW-1:0] ack_sig_d [AOR_CH_COUNT];
  logic [AOR_DW-1:0] force_sig_q [AOR_CH_COUNT];
  logic [AOR_DW-1:0] force_sig_d [AOR_CH_COUNT];
  logic [AOR_FORCE_W-1:0] force_q [AOR_CH_COUNT];
  logic [AOR_FORCE_W-1:0] force_d [AOR_CH_COUNT];
  logic [AOR_DW-1:0] gw_status_sig_q, gw_status_sig_d;
  logic [AOR_DW-1:0] gw_version_sig_q, gw_version_sig_d;
  logic [7:0] main_ver_q, main_ver_d;
  logic [15:0] patch_ver_q, patch_ver_d;
  logic [7:0] hw_rev_q, hw_rev_d;
  logic [47:0] node_id_q, node_id_d;
  logic pw_active_q, pw_active_d;
  logic [AOR_CH_COUNT-1:0] ack_d;
  logic [AOR_DW-1:0] rdata_d;
  logic err_d;
  logic unlocked;
  logic [AOR_CHW-1:0] ch;
  logic ch_ok;
  logic [11:0] ofs;
  logic wr_open;

  // upper or lower half of one channel's float32
  function automatic logic [15:0] f_word(input logic [AOR_CH_COUNT*32-1:0] v,
                                         input logic [AOR_CHW-1:0] c,
                                         input logic hi);
    logic [31:0] w;
    w = v[32*c +: 32];
    f_word = hi ? w[31:16] : w[15:0];
  endfunction

  // signature after an access: store on write, step down on read
  function automatic logic [15:0] f_sig(input logic [15:0] cur, input logic wr,
                                        input logic rd, input logic [15:0] wd);
    f_sig = cur;
    if (wr) begin
      f_sig = wd;
    end else if (rd) begin
      f_sig = cur - 16'h0001;
    end
  endfunction

  aor_unlock_timer #(
    .UNLOCK_CYCLES(UNLOCK_CYCLES)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .login_ok_i(login_ok_i),
    .unlocked_o(unlocked)
  );

  // address split
  assign ch = reg_addr_i[12 +: AOR_CHW];
  assign ch_ok = (reg_addr_i[15:12] < 4'(AOR_CH_COUNT));
  assign ofs = reg_addr_i[11:0];
  assign wr_open = !pw_active_q || unlocked;

  // next state of the register bank and the read answer
  always_comb begin
    ack_sig_d = ack_sig_q;
    force_sig_d = force_sig_q;
    force_d = force_q;
    gw_status_sig_d = gw_status_sig_q;
    gw_version_sig_d = gw_version_sig_q;
    main_ver_d = main_ver_q;
    patch_ver_d = patch_ver_q;
    hw_rev_d = hw_rev_q;
    node_id_d = node_id_q;
    pw_active_d = pw_active_q;
    ack_d = '0;
    rdata_d = '0;
    err_d = 1'b0;
    if (ch_ok) begin
      case (ofs)
        AOR_OFS_MEAN1_UPPER: begin
          if (reg_rd_i) rdata_d = f_word(mean_one_i, ch, 1'b0);
          err_d = reg_wr_i;
        end
        AOR_OFS_MEAN2_FIRST: begin
          if (reg_rd_i) rdata_d = f_word(mean_two_i, ch, 1'b1);
          err_d = reg_wr_i;
        end
        AOR_OFS_MEAN2_SECOND: begin
          if (reg_rd_i) rdata_d = f_word(mean_two_i, ch, 1'b0);
          err_d = reg_wr_i;
        end
        AOR_OFS_ACK_SIG: begin
          if (reg_rd_i) rdata_d = ack_sig_q[ch];
          ack_sig_d[ch] = f_sig(ack_sig_q[ch], reg_wr_i, reg_rd_i, reg_wdata_i);
        end
        AOR_OFS_ACK: begin
          rdata_d = '0;
          if (reg_wr_i && reg_wdata_i[AOR_ACK_BIT]) ack_d[ch] = 1'b1;
        end
        AOR_OFS_FORCE_SIG: begin
          if (reg_rd_i) rdata_d = force_sig_q[ch];
          if (reg_wr_i && !wr_open) begin
            err_d = 1'b1;
          end else begin
            force_sig_d[ch] = f_sig(force_sig_q[ch], reg_wr_i, reg_rd_i, reg_wdata_i);
          end
        end
        AOR_OFS_FORCE: begin
          if (reg_rd_i) rdata_d = {8'h00, force_q[ch]};
          if (reg_wr_i && !wr_open) begin
            err_d = 1'b1;
          end else if (reg_wr_i) begin
            force_d[ch] = reg_wdata_i[AOR_FORCE_W-1:0];
          end
        end
        default: begin
          err_d = reg_wr_i || reg_rd_i;
        end
      endcase
    end else begin
      case (reg_addr_i)
        AOR_ADR_GW_STATUS_SIG: begin
          if (reg_rd_i) rdata_d = gw_status_sig_q;
          gw_status_sig_d = f_sig(gw_status_sig_q, reg_wr_i, reg_rd_i, reg_wdata_i);
        end
        AOR_ADR_GW_RESERVED: begin
          rdata_d = '0;
        end
        AOR_ADR_GW_VERSION_SIG: begin
          if (reg_rd_i) rdata_d = gw_version_sig_q;
          gw_version_sig_d = f_sig(gw_version_sig_q, reg_wr_i, reg_rd_i, reg_wdata_i);
        end
        AOR_ADR_GW_MAIN_VER: begin
          if (reg_wr_i) main_ver_d = reg_wdata_i[7:0];
        end
        AOR_ADR_GW_PATCH_VER: begin
          if (reg_wr_i) patch_ver_d = reg_wdata_i;
        end
        AOR_ADR_GW_HW_REV: begin
          if (reg_wr_i) hw_rev_d = reg_wdata_i[7:0];
        end
        AOR_ADR_NODE_ID_LOW: begin
          if (reg_wr_i) node_id_d[15:0] = reg_wdata_i;
        end
        AOR_ADR_NODE_ID_MID: begin
          if (reg_wr_i) node_id_d[31:16] = reg_wdata_i;
        end
        AOR_ADR_NODE_ID_HIGH: begin
          if (reg_wr_i) node_id_d[47:32] = reg_wdata_i;
        end
        AOR_ADR_PW_FLAGS, AOR_ADR_PW_FLAGS_INV: begin
          if (reg_rd_i) begin
            rdata_d = {15'h0000, pw_active_q};
            if (reg_addr_i == AOR_ADR_PW_FLAGS_INV) rdata_d = ~rdata_d;
          end
          if (reg_wr_i && !unlocked) begin
            err_d = 1'b1;
          end else if (reg_wr_i) begin
            pw_active_d = (reg_addr_i == AOR_ADR_PW_FLAGS) ?
                          reg_wdata_i[AOR_PW_ACTIVE_BIT] : !reg_wdata_i[AOR_PW_ACTIVE_BIT];
          end
        end
        default: begin
          err_d = reg_wr_i || reg_rd_i;
        end
      endcase
    end
  end

  // registers; a restart clears every forced state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < AOR_CH_COUNT; i++) begin
        ack_sig_q[i] <= AOR_SIG_RESET;
        force_sig_q[i] <= AOR_SIG_RESET;
        force_q[i] <= AOR_FORCE_RESET;
      end
      gw_status_sig_q <= AOR_SIG_RESET;
      gw_version_sig_q <= AOR_SIG_RESET;
      main_ver_q <= '0;
      patch_ver_q <= '0;
      hw_rev_q <= '0;
      node_id_q <= '0;
      pw_active_q <= AOR_PW_ACTIVE_RESET;
      alarm_ack_o <= '0;
      reg_rdata_o <= '0;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else begin
      ack_sig_q <= ack_sig_d;
      force_sig_q <= force_sig_d;
      force_q <= force_d;
      gw_status_sig_q <= gw_status_sig_d;
      gw_version_sig_q <= gw_version_sig_d;
      main_ver_q <= main_ver_d;
      patch_ver_q <= patch_ver_d;
      hw_rev_q <= hw_rev_d;
      node_id_q <= node_id_d;
      pw_active_q <= pw_active_d;
      alarm_ack_o <= ack_d;
      reg_rdata_o <= rdata_d;
      reg_ack_o <= reg_rd_i || reg_wr_i;
      reg_err_o <= err_d;
    end
  end

  // flop-driven status outputs
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      forced_state_o <= '0;
      password_active_o <= AOR_PW_ACTIVE_RESET;
      write_unlocked_o <= 1'b0;
      gateway_main_version_o <= '0;
      gateway_patch_sub_version_o <= '0;
      gateway_hardware_revision_o <= '0;
      unique_node_identifier_o <= '0;
    end else begin
      for (int i = 0; i < AOR_CH_COUNT; i++) begin
        forced_state_o[AOR_FORCE_W*i +: AOR_FORCE_W] <= force_d[i];
      end
      password_active_o <= pw_active_d;
      write_unlocked_o <= unlocked;
      gateway_main_version_o <= main_ver_d;
      gateway_patch_sub_version_o <= patch_ver_d;
      gateway_hardware_revision_o <= hw_rev_d;
      unique_node_identifier_o <= node_id_d;
    end
  end
endmodule

// [logic/aor_unlock_timer.sv]
`timescale 1ns/1ps
module aor_unlock_timer
  import aor_pkg::*;
#(
  parameter logic [AOR_TIMER_W-1:0] UNLOCK_CYCLES = AOR_TIMER_W'(AOR_UNLOCK_CYCLES)
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic login_ok_i,
  output logic unlocked_o
);
  logic [AOR_TIMER_W-1:0] cnt_q;
  logic [AOR_TIMER_W-1:0] cnt_d;
  logic unlocked_d;

  // a login (re)starts the window, expiry only relocks writes
  always_comb begin
    cnt_d = cnt_q;
    unlocked_d = unlocked_o;
    if (login_ok_i) begin
      cnt_d = UNLOCK_CYCLES;
      unlocked_d = 1'b1;
    end else if (cnt_q > AOR_TIMER_W'(1)) begin
      cnt_d = cnt_q - AOR_TIMER_W'(1);
    end else begin
      cnt_d = '0;
      unlocked_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      unlocked_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      unlocked_o <= unlocked_d;
    end
  end
endmodule

// [pkg/aor_pkg.sv]
package aor_pkg;
  // bus and channel geometry
  localparam int AOR_DW = 16;
  localparam int AOR_AW = 16;
  localparam int AOR_CH_COUNT = 8;
  localparam int AOR_CHW = 3;
  localparam int AOR_FORCE_W = 8;

  // per-channel offsets, the channel number sits in address bits 15:12
  localparam logic [11:0] AOR_OFS_MEAN1_UPPER = 12'h406;
  localparam logic [11:0] AOR_OFS_MEAN2_FIRST = 12'h407;
  localparam logic [11:0] AOR_OFS_MEAN2_SECOND = 12'h408;
  localparam logic [11:0] AOR_OFS_ACK_SIG = 12'h500;
  localparam logic [11:0] AOR_OFS_ACK = 12'h501;
  localparam logic [11:0] AOR_OFS_FORCE_SIG = 12'h502;
  localparam logic [11:0] AOR_OFS_FORCE = 12'h503;

  // gateway status and version area
  localparam logic [15:0] AOR_ADR_GW_STATUS_SIG = 16'hA000;
  localparam logic [15:0] AOR_ADR_GW_RESERVED = 16'hA001;
  localparam logic [15:0] AOR_ADR_GW_VERSION_SIG = 16'hA010;
  localparam logic [15:0] AOR_ADR_GW_MAIN_VER = 16'hA011;
  localparam logic [15:0] AOR_ADR_GW_PATCH_VER = 16'hA012;
  localparam logic [15:0] AOR_ADR_GW_HW_REV = 16'hA013;
  localparam logic [15:0] AOR_ADR_NODE_ID_LOW = 16'hA014;
  localparam logic [15:0] AOR_ADR_NODE_ID_MID = 16'hA015;
  localparam logic [15:0] AOR_ADR_NODE_ID_HIGH = 16'hA016;

  // password flag word and its bit inversion
  localparam logic [15:0] AOR_ADR_PW_FLAGS = 16'hA106;
  localparam logic [15:0] AOR_ADR_PW_FLAGS_INV = 16'hA107;
  localparam int AOR_PW_ACTIVE_BIT = 0;

  // field positions
  localparam int AOR_ACK_BIT = 0;
  localparam int AOR_FORCE_FAULT_BIT = 0;
  localparam int AOR_FORCE_ALARM1_BIT = 4;

  // values after reset
  localparam logic [15:0] AOR_SIG_RESET = 16'h0000;
  localparam logic [7:0] AOR_FORCE_RESET = 8'h00;
  localparam logic AOR_PW_ACTIVE_RESET = 1'b1;

  // unlock window after login
  localparam longint AOR_UNLOCK_MINUTES = 30;
  localparam longint AOR_CLK_HZ = 40000000;
  localparam longint AOR_UNLOCK_CYCLES = AOR_UNLOCK_MINUTES * 64'd60 * AOR_CLK_HZ;
  localparam int AOR_TIMER_W = 40;
endpackage

// [testbench/aor_master.sv]
`timescale 1ns/1ps
// modbus-side master and gateway: one strobe per access
module aor_master
  import aor_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [AOR_DW-1:0] rdata_i,
  input wire logic ack_i,
  input wire logic err_i,
  output logic [AOR_AW-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [AOR_DW-1:0] wdata_o
);
  // idle bus at time zero
  initial begin
    addr_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = '0;
  end
  // strobe for one cycle, keep address and data, answer is read at the next falling edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic e, output logic ok);
    int n;
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge ref_clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    ok = (ack_i === 1'b1);
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge ref_clk_i);
      ok = (ack_i === 1'b1);
    end
    q = rdata_i;
    e = err_i;
  endtask
  // gateway announces its versions; ok_all low if any write went unanswered
  task automatic gw_version(input logic [7:0] mv, pv, sv, hv, output logic ok_all);
    logic [15:0] q;
    logic e, ok1, ok2, ok3;
    acc(1'b1, AOR_ADR_GW_MAIN_VER, {8'h00, mv}, q, e, ok1);
    acc(1'b1, AOR_ADR_GW_PATCH_VER, {sv, pv}, q, e, ok2);
    acc(1'b1, AOR_ADR_GW_HW_REV, {8'h00, hv}, q, e, ok3);
    ok_all = ok1 && ok2 && ok3;
  endtask
endmodule

// [testbench/aor_regs_asserts.sv]
`timescale 1ns/1ps
// port-level checks for the register bank
module aor_regs_asserts
  import aor_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [AOR_AW-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [AOR_DW-1:0] reg_wdata_i,
  input wire logic [AOR_DW-1:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic reg_err_o,
  input wire logic login_ok_i,
  input wire logic [AOR_CH_COUNT*32-1:0] mean_two_i,
  input wire logic [AOR_CH_COUNT-1:0] alarm_ack_o,
  input wire logic [AOR_CH_COUNT*AOR_FORCE_W-1:0] forced_state_o,
  input wire logic password_active_o,
  input wire logic write_unlocked_o,
  input wire logic [47:0] unique_node_identifier_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // address split and sampled slices
  wire logic [11:0] ofs = reg_addr_i[11:0];
  wire logic chn_ok = reg_addr_i[15:12] < 4'h8;
  wire logic [7:0] wlo = reg_wdata_i[7:0];
  wire logic [15:0] m3hi = mean_two_i[127:112];
  // two reads of one signature word, two cycles apart
  sequence sig_reads;
    reg_rd_i && reg_addr_i == AOR_ADR_GW_STATUS_SIG ##2
      reg_rd_i && reg_addr_i == AOR_ADR_GW_STATUS_SIG;
  endsequence
  // forced-state write taken while the window was open
  sequence force_wr_open;
    reg_wr_i && reg_addr_i == 16'h1503 ##1 write_unlocked_o;
  endsequence
  ack_timing_a: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o)
    else $error("no answer after strobe");
  ack_cause_a: assert property (reg_ack_o |-> $past(reg_rd_i) || $past(reg_wr_i))
    else $error("answer without strobe");
  sig_dec_a: assert property (sig_reads |-> ##1 reg_rdata_o == $past(reg_rdata_o, 2) - 16'h1)
    else $error("signature did not count down");
  reset_clear_a: assert property (disable iff (1'b0) !rst_n_i |=>
    forced_state_o == '0 && password_active_o) else $error("restart left state");
  refuse_lock_a: assert property (reg_wr_i && ofs == AOR_OFS_FORCE && chn_ok &&
    password_active_o && !write_unlocked_o && !$past(login_ok_i) |=>
    reg_err_o && $stable(forced_state_o)) else $error("locked write taken");
  ack_pulse_a: assert property (reg_wr_i && reg_addr_i == 16'h2501 && reg_wdata_i[0] |=>
    alarm_ack_o == 8'h04 ##1 alarm_ack_o == 8'h00) else $error("bad acknowledge pulse");
  ack_read_a: assert property (reg_rd_i && ofs == AOR_OFS_ACK |=> reg_rdata_o == 16'h0)
    else $error("acknowledge word not zero");
  force_write_a: assert property (force_wr_open |-> forced_state_o[15:8] == $past(wlo))
    else $error("forced bits not stored");
  force_upper_a: assert property (reg_rd_i && ofs == AOR_OFS_FORCE |=>
    reg_rdata_o[15:8] == 8'h00) else $error("forced upper byte set");
  mean_hi_a: assert property (reg_rd_i && reg_addr_i == 16'h3407 |=>
    reg_rdata_o == $past(m3hi)) else $error("mean upper word wrong");
  mean_ro_a: assert property (reg_wr_i && chn_ok && (ofs == AOR_OFS_MEAN2_FIRST ||
    ofs == AOR_OFS_MEAN2_SECOND) |=> reg_err_o) else $error("mean write not refused");
  node_low_a: assert property (reg_wr_i && reg_addr_i == AOR_ADR_NODE_ID_LOW |=>
    unique_node_identifier_o[15:0] == $past(reg_wdata_i)) else $error("node id low wrong");
endmodule

bind aor_regs aor_regs_asserts i_aor_regs_asserts (.*);

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import aor_pkg::*;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, login_ok_i = 1'b0;
  logic [255:0] mean_one_i = {8{32'h3F800000}}, mean_two_i = '0;
  logic [15:0] addr, wdata, rdata, q;
  logic wr, rd, ack, err, e, ok, pw, unl;
  logic [7:0] alarm_ack, mainv, hwv;
  logic [15:0] patchv;
  logic [63:0] forced;
  logic [47:0] nid;
  logic [15:0] sa [4] = '{16'h0500, 16'h1502, 16'hA000, 16'hA010};
  int bad_count = 0, checked = 0, n;
  always #12.5 ref_clk_i = ~ref_clk_i;
  aor_regs #(.UNLOCK_CYCLES(40'd100)) i_aor_regs (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
    .login_ok_i(login_ok_i), .mean_one_i(mean_one_i), .mean_two_i(mean_two_i),
    .alarm_ack_o(alarm_ack), .forced_state_o(forced), .password_active_o(pw),
    .write_unlocked_o(unl), .gateway_main_version_o(mainv),
    .gateway_patch_sub_version_o(patchv), .gateway_hardware_revision_o(hwv),
    .unique_node_identifier_o(nid));
  aor_master i_aor_master (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .ack_i(ack),
    .err_i(err), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one register access; a missing answer ends the run
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    i_aor_master.acc(w, a, d, q, e, ok);
    if (!ok) begin
      bad_count++;
      test_done();
    end
  endtask
  // login pulse, then checks that the window shows open one cycle after it ends
  task automatic login;
    @(negedge ref_clk_i);
    login_ok_i = 1'b1;
    @(negedge ref_clk_i);
    login_ok_i = 1'b0;
    @(negedge ref_clk_i);
    chk(unl, 1'b1, "window_open");
  endtask
  // bounded wait for the window to close
  task automatic wait_close;
    for (n = 0; n < 300 && unl !== 1'b0; n++) @(negedge ref_clk_i);
    chk(unl, 1'b0, "window_closed");
  endtask
  initial begin
    mean_two_i[127:96] = 32'h40490FDB;
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk(pw, 1'b1, "pw_after_reset");
    chk(forced, '0, "forced_after_reset");
    foreach (sa[i]) begin
      acc(1'b0, sa[i], 16'h0);
      chk(q, 16'h0000, "sig_first");
      acc(1'b0, sa[i], 16'h0);
      chk(q, 16'hFFFF, "sig_second");
    end
    acc(1'b1, 16'hA000, 16'h0005);
    acc(1'b0, 16'hA000, 16'h0);
    chk(q, 16'h0005, "sig_written");
    acc(1'b1, 16'h1503, 16'h00FF);
    chk({e, forced[15:8]}, 9'h100, "locked_force");
    acc(1'b1, 16'h1502, 16'h0007);
    chk(e, 1'b1, "locked_sig");
    login();
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 16'h1503, 16'hFF00 | (16'h1 << i));
      chk(forced[15:8], 8'h1 << i, "force_bit");
    end
    acc(1'b0, 16'h1503, 16'h0);
    chk(q, 16'h0080, "force_read");
    acc(1'b1, 16'h1503, 16'h0011);
    wait_close();
    chk(forced[15:8], 8'h11, "force_kept");
    acc(1'b1, 16'h1503, 16'h0000);
    chk({e, forced[15:8]}, 9'h111, "relocked");
    acc(1'b1, 16'h2501, 16'h0001);
    chk(alarm_ack, 8'h04, "ack_pulse");
    acc(1'b0, 16'h2501, 16'h0);
    chk({alarm_ack, q}, 24'h0, "ack_read");
    acc(1'b0, 16'h3407, 16'h0);
    chk(q, 16'h4049, "mean_hi");
    acc(1'b0, 16'h3408, 16'h0);
    chk(q, 16'h0FDB, "mean_lo");
    acc(1'b0, 16'h0406, 16'h0);
    chk(q, 16'h0000, "mean_one_lo");
    acc(1'b1, 16'h3408, 16'h1234);
    chk(e, 1'b1, "mean_ro");
    i_aor_master.gw_version(8'h12, 8'h34, 8'h56, 8'h00, ok);
    if (!ok) begin
      bad_count++;
      test_done();
    end
    chk({mainv, patchv, hwv}, 32'h12563400, "gw_versions");
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 16'(AOR_ADR_NODE_ID_LOW + i), 16'(16'h1111 * (i + 1)));
    end
    chk(nid, 48'h333322221111, "node_id");
    acc(1'b1, AOR_ADR_GW_RESERVED, 16'hBEEF);
    chk(e, 1'b0, "reserved_write");
    acc(1'b0, 16'h9503, 16'h0);
    chk(e, 1'b1, "unmapped");
    acc(1'b1, AOR_ADR_PW_FLAGS, 16'h0);
    chk({e, pw}, 2'b11, "pw_locked");
    login();
    acc(1'b1, AOR_ADR_PW_FLAGS, 16'h0);
    chk(pw, 1'b0, "pw_cleared");
    wait_close();
    acc(1'b1, 16'h1503, 16'h0003);
    chk({e, forced[15:8]}, 9'h003, "unprotected");
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk(forced, 64'h0, "restart_forced");
    chk(pw, 1'b1, "restart_pw");
    test_done();
  end
endmodule
